/* File: rtl/elpa_ability_reg.sv */
// emulated link partner base page ability register of the emulated phy
// assumes the auto-negotiation engine pulses anDone/anRestart on this clock;
// host access arrives as a read strobe on the parallel map or the mii management side
`timescale 1ns/1ps

// Function
// - register is 32 bits on the map, upper half reserved; 16 bits over mii management.
// - bit 15 next page always reads 0.
// - bit 14 acknowledge always reads 1.
// - bit 13 remote fault always reads 0.
// - bit 9 100BASE-T4 always reads 0.
// - selector field bits 4:0 always read 00001.
// - no local pause gives 00; symmetric only gives symmetric 1, asymmetric 0.
// - local asymmetric only gives both partner pause bits set.
// - both local pause bits: strap 1 gives both set, else asymmetric only.
// - pause bits captured at negotiation completion; later advert writes ignored.
// - speed/duplex bits 8..5 follow duplex pin, polarity strap, speed strap, success.
// - strap inputs sampled at reset release and held until next reset.
// - pin equals polarity gives full duplex 0010/1000, else half 0001/0100.
// - negotiation fails when local and partner abilities share no bit.
module elpa_ability_reg
  import elpa_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         clkEn,
  input  wire elpa_straps_s strapPins,
  input  wire logic         portDuplexPin,
  input  wire elpa_advert_s localAdvertReg,
  input  wire logic         anDone,
  input  wire logic         anRestart,
  input  wire logic         mapRead,
  input  wire logic [11:0]  mapAddr,
  input  wire logic         mapWrite,
  input  wire logic [31:0]  mapWdata,
  input  wire logic         miiRead,
  input  wire logic [4:0]   miiRegAddr,
  output logic [31:0]       mapRdata,
  output logic              mapRvalid,
  output logic [15:0]       miiRdata,
  output logic              miiRvalid,
  output logic              anFailed,
  output logic [15:0]       abilityWord
);

  typedef enum logic [1:0] {
    AN_IDLE = 2'b00,
    AN_RUN  = 2'b01,
    AN_OK   = 2'b10,
    AN_FAIL = 2'b11
  } elpa_an_e;

  elpa_straps_s straps;
  elpa_an_e     anState_ff;
  elpa_an_e     nxt_anState;
  logic [1:0]   pause_ff;
  logic [3:0]   speed_ff;
  logic         dupSync1_ff;
  logic         dupSync2_ff;
  logic         dupSync3_ff;
  logic         duplex_ff;
  logic [31:0]  mapRdata_ff;
  logic         mapRvalid_ff;
  logic [15:0]  miiRdata_ff;
  logic         miiRvalid_ff;
  logic         anFailed_ff;
  logic [15:0]  word_ff;

  elpa_strap_latch uStraps (
    .clock     (clock),
    .rst       (rst),
    .clkEn     (clkEn),
    .strapPins (strapPins),
    .straps    (straps)
  );

  // partner pause from the local advertisement; table is the whole behaviour
  function automatic logic [1:0] partner_pause(input logic sym, input logic asym, input logic dual);
    logic [1:0] res;
    res = 2'h0;
    case ({sym, asym})
      2'b00:   res = 2'h0;
      2'b10:   res = 2'h1;
      2'b01:   res = 2'h3;
      2'b11:   res = dual ? 2'h3 : 2'h2;
      default: res = 2'h0;
    endcase
    return res; // bit1 asymmetric, bit0 symmetric
  endfunction

  // duplex pin is off-domain: three stages, change accepted when stages 2 and 3 agree
  always_ff @(posedge clock) begin
    if (rst) begin
      dupSync1_ff <= 1'b0;
      dupSync2_ff <= 1'b0;
      dupSync3_ff <= 1'b0;
      duplex_ff   <= 1'b0;
    end else if (clkEn) begin
      dupSync1_ff <= portDuplexPin;
      dupSync2_ff <= dupSync1_ff;
      dupSync3_ff <= dupSync2_ff;
      if (dupSync2_ff == dupSync3_ff)
        duplex_ff <= dupSync3_ff;
    end
  end

  wire        fullDuplex  = (duplex_ff == straps.duplexPol);
  wire [3:0]  partnerAbil = fullDuplex ? (straps.speedSel ? ABIL_100FD : ABIL_10FD)
                                       : (straps.speedSel ? ABIL_100HD : ABIL_10HD);
  wire        commonAbil  = |(partnerAbil & localAdvertReg.speedDuplex);
  wire [1:0]  newPause    = partner_pause(localAdvertReg.symPause, localAdvertReg.asymPause,
                                          straps.dualPauseChoice);
  wire        doneEvt     = (anState_ff == AN_RUN) && anDone;

  always_comb begin
    nxt_anState = anState_ff;
    case (anState_ff)
      AN_IDLE: nxt_anState = anRestart ? AN_RUN : AN_IDLE;
      AN_RUN:  nxt_anState = anDone ? (commonAbil ? AN_OK : AN_FAIL) : AN_RUN;
      AN_OK:   nxt_anState = anRestart ? AN_RUN : AN_OK;
      AN_FAIL: nxt_anState = anRestart ? AN_RUN : AN_FAIL;
      default: nxt_anState = AN_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      anState_ff <= AN_IDLE;
      pause_ff   <= PAUSE_RST;
      speed_ff   <= ABIL_RST;
    end else if (clkEn) begin
      anState_ff <= nxt_anState;
      if (doneEvt) begin
        pause_ff <= newPause;
        speed_ff <= commonAbil ? partnerAbil : ABIL_RST;
      end
    end
  end

  // a failed negotiation reports no speed ability; writes never reach this word
  wire [15:0] word = {NEXT_PAGE_VAL,
                      ACK_VAL,
                      REMOTE_FLT_VAL,
                      1'b0,
                      pause_ff,
                      T4_VAL,
                      speed_ff,
                      SELECTOR_VAL};

  wire mapHit = (mapAddr == ELPA_ABILITY_OFS);
  wire miiHit = (miiRegAddr == 5'(ELPA_ABILITY_IDX));

  // mapWrite/mapWdata are accepted and dropped: the register is read-only
  wire unusedWrite = mapWrite & (|mapWdata);

  always_ff @(posedge clock) begin
    if (rst) begin
      mapRdata_ff  <= 32'h0;
      mapRvalid_ff <= 1'b0;
      miiRdata_ff  <= 16'h0;
      miiRvalid_ff <= 1'b0;
      anFailed_ff  <= 1'b0;
      word_ff      <= 16'h0;
    end else if (clkEn) begin
      mapRvalid_ff <= mapRead;
      mapRdata_ff  <= (mapRead && mapHit) ? {16'h0, word} : 32'h0;
      miiRvalid_ff <= miiRead;
      miiRdata_ff  <= (miiRead && miiHit) ? word : 16'h0;
      anFailed_ff  <= (anState_ff == AN_FAIL);
      word_ff      <= word;
    end
  end

  assign mapRdata    = mapRdata_ff;
  assign mapRvalid   = mapRvalid_ff;
  assign miiRdata    = miiRdata_ff;
  assign miiRvalid   = miiRvalid_ff;
  assign anFailed    = anFailed_ff;
  assign abilityWord = word_ff;

endmodule

/* File: rtl/elpa_pkg.sv */
// package for the emulated link partner ability register
// assumes a single 25 MHz system clock and synchronous active-high reset
package elpa_pkg;

  localparam logic [11:0] ELPA_ABILITY_OFS = 12'h1d4;
  localparam int          ELPA_ABILITY_IDX = 5;

  localparam int NEXT_PAGE_BIT   = 15;
  localparam int ACK_BIT         = 14;
  localparam int REMOTE_FLT_BIT  = 13;
  localparam int RSVD_BIT        = 12;
  localparam int ASYM_PAUSE_BIT  = 11;
  localparam int SYM_PAUSE_BIT   = 10;
  localparam int T4_BIT          = 9;
  localparam int SPEED_HI_BIT    = 8;
  localparam int SPEED_LO_BIT    = 5;
  localparam int SELECTOR_HI_BIT = 4;

  localparam logic       NEXT_PAGE_VAL  = 1'b0;
  localparam logic       ACK_VAL        = 1'b1;
  localparam logic       REMOTE_FLT_VAL = 1'b0;
  localparam logic       T4_VAL         = 1'b0;
  localparam logic [4:0] SELECTOR_VAL   = 5'h01;

  localparam logic [3:0] ABIL_10FD  = 4'h2;
  localparam logic [3:0] ABIL_100FD = 4'h8;
  localparam logic [3:0] ABIL_10HD  = 4'h1;
  localparam logic [3:0] ABIL_100HD = 4'h4;

  // reset values of captured state
  localparam logic [1:0] PAUSE_RST = 2'h0;
  localparam logic [3:0] ABIL_RST  = 4'h0;

  // straps latched at reset release
  typedef struct packed {
    logic dualPauseChoice;
    logic duplexPol;
    logic speedSel;
  } elpa_straps_s;

  // local advertisement bits seen by the partner emulation
  typedef struct packed {
    logic       asymPause;
    logic       symPause;
    logic [3:0] speedDuplex;
  } elpa_advert_s;

endpackage

/* File: rtl/elpa_strap_latch.sv */
// strap capture: takes pin levels at the first enabled edge after reset release
// assumes straps are stable around reset release; pins pass a 3-stage synchroniser
`timescale 1ns/1ps
module elpa_strap_latch
  import elpa_pkg::*;
(
  input  wire logic         clock,
  input  wire logic         rst,
  input  wire logic         clkEn,
  input  wire elpa_straps_s strapPins,
  output elpa_straps_s      straps
);

  elpa_straps_s sync1_ff;
  elpa_straps_s sync2_ff;
  elpa_straps_s sync3_ff;
  logic         captured_ff;
  elpa_straps_s straps_ff;

  // second and third stage agreeing marks a settled level
  wire settled = (sync2_ff == sync3_ff);

  always_ff @(posedge clock) begin
    if (clkEn) begin
      sync1_ff <= strapPins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      captured_ff <= 1'b0;
      straps_ff   <= '0;
    end else if (clkEn && !captured_ff && settled) begin
      captured_ff <= 1'b1;
      straps_ff   <= sync3_ff;
    end
  end

  assign straps = straps_ff;

endmodule

/* File: tb/elpa_ability_reg_monitor.sv */
// checker for the ability register ports
// bound to elpa_ability_reg; one clock, synchronous reset
`timescale 1ns/1ps
module elpa_ability_reg_monitor
  import elpa_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        clkEn,
  input wire logic        anDone,
  input wire logic        mapRead,
  input wire logic [11:0] mapAddr,
  input wire logic        miiRead,
  input wire logic [31:0] mapRdata,
  input wire logic        mapRvalid,
  input wire logic        miiRvalid,
  input wire logic        anFailed,
  input wire logic [15:0] abilityWord
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // three quiet edges keep the reset load out of the stability check
  sequence quiet3;
    (clkEn && !anDone)[*3];
  endsequence
  a_map_answer: assert property (clkEn && mapRead |=> mapRvalid) else $error("map read unanswered");
  a_mii_answer: assert property (clkEn && miiRead |=> miiRvalid) else $error("mii read unanswered");
  a_upper_zero: assert property (mapRvalid |-> mapRdata[31:16] == 16'h0) else $error("upper half set");
  a_miss_zero: assert property (clkEn && mapRead && mapAddr != ELPA_ABILITY_OFS |=> mapRdata == 32'h0)
    else $error("miss data not zero");
  a_fixed_bits: assert property (clkEn && mapRead && mapAddr == ELPA_ABILITY_OFS |=>
    mapRdata[15:12] == 4'h4 && !mapRdata[9] && mapRdata[4:0] == 5'h01) else $error("fixed bits wrong");
  a_word_held: assert property (quiet3 ##1 1'b1 |-> $stable(abilityWord)) else $error("word moved");
  a_fail_speed: assert property (anFailed |-> abilityWord[8:5] == 4'h0) else $error("speed set on fail");
  a_speed_one: assert property ($onehot0(abilityWord[8:5])) else $error("speed not one hot");
endmodule

bind elpa_ability_reg elpa_ability_reg_monitor u_mon (.clock(clock), .rst(rst), .clkEn(clkEn),
  .anDone(anDone), .mapRead(mapRead), .mapAddr(mapAddr), .miiRead(miiRead), .mapRdata(mapRdata),
  .mapRvalid(mapRvalid), .miiRvalid(miiRvalid), .anFailed(anFailed), .abilityWord(abilityWord));

/* File: tb/elpa_host_model.sv */
// host model: map and mii management reads, map writes
// assumes requests start at a falling edge; data taken at the next falling edge
`timescale 1ns/1ps
module elpa_host_model (
  input  wire logic        clock,
  input  wire logic [31:0] mapRdata,
  input  wire logic [15:0] miiRdata,
  output logic             mapRead,
  output logic [11:0]      mapAddr,
  output logic             mapWrite,
  output logic [31:0]      mapWdata,
  output logic             miiRead,
  output logic [4:0]       miiRegAddr
);
  initial begin
    {mapRead, mapWrite, miiRead, mapAddr, mapWdata, miiRegAddr} = 52'h0;
  end
  // released address lines show the inverse so a stale value never matches
  task automatic access(input logic mii, input logic wr, input logic [11:0] a, output logic [31:0] d);
    @(negedge clock);
    mapRead = !mii && !wr;
    mapWrite = wr;
    miiRead = mii;
    mapAddr = a;
    miiRegAddr = a[4:0];
    mapWdata = 32'hffffffff;
    @(negedge clock);
    {mapRead, mapWrite, miiRead} = 3'h0;
    mapAddr = ~a;
    miiRegAddr = ~a[4:0];
    d = mii ? {16'h0, miiRdata} : mapRdata;
  endtask
endmodule

/* File: tb/tb.sv */
// self-checking bench for the ability register with a host model
// assumes clkEn always high; straps are set during reset and inverted once after each first negotiation
`timescale 1ns/1ps
module tb;
  import elpa_pkg::*;
  logic         clock, rst, pin, anDone, anRestart, mapRead, mapWrite, miiRead, mapRvalid, miiRvalid, anFailed;
  logic [11:0]  mapAddr;
  logic [4:0]   miiRegAddr;
  logic [31:0]  mapWdata, mapRdata, d, seed = 32'h5d24513f;
  logic [15:0]  miiRdata, abilityWord, w;
  elpa_straps_s strapPins;
  elpa_advert_s adv;
  int           error_cnt = 0, checked = 0;
  elpa_ability_reg uut (.clock(clock), .rst(rst), .clkEn(1'b1), .strapPins(strapPins), .portDuplexPin(pin),
    .localAdvertReg(adv), .anDone(anDone), .anRestart(anRestart), .mapRead(mapRead), .mapAddr(mapAddr),
    .mapWrite(mapWrite), .mapWdata(mapWdata), .miiRead(miiRead), .miiRegAddr(miiRegAddr), .mapRdata(mapRdata),
    .mapRvalid(mapRvalid), .miiRdata(miiRdata), .miiRvalid(miiRvalid), .anFailed(anFailed), .abilityWord(abilityWord));
  elpa_host_model host (.clock(clock), .mapRdata(mapRdata), .miiRdata(miiRdata), .mapRead(mapRead),
    .mapAddr(mapAddr), .mapWrite(mapWrite), .mapWdata(mapWdata), .miiRead(miiRead), .miiRegAddr(miiRegAddr));
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    y = y ^ (y << 5);
    return y;
  endfunction
  function automatic logic [15:0] expWord(elpa_straps_s s, logic p, elpa_advert_s a);
    logic [3:0] sp;
    logic [1:0] pz;
    sp = s.speedSel ? (p == s.duplexPol ? 4'h8 : 4'h4) : (p == s.duplexPol ? 4'h2 : 4'h1);
    if ((sp & a.speedDuplex) == 4'h0) sp = 4'h0;
    pz = {a.asymPause | a.symPause & ~a.asymPause, a.asymPause ^ a.symPause | a.symPause & s.dualPauseChoice};
    if ({a.asymPause, a.symPause} == 2'b01) pz = 2'b01;
    return {4'h4, pz, 1'b0, sp, 5'h01};
  endfunction
  task automatic chk(string n, logic [31:0] seen, logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic negotiate;
    @(negedge clock) anRestart = 1'b1;
    @(negedge clock) anRestart = 1'b0;
    anDone = 1'b1;
    @(negedge clock) anDone = 1'b0;
    repeat (3) @(negedge clock);
  endtask
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  initial begin
    #400000;
    error_cnt++;
    end_sim();
  end
  initial begin
    {rst, pin, anDone, anRestart, strapPins, adv} = 13'h1000;
    for (int i = 0; i < 16; i++) begin
      seed = xorshift(seed);
      @(negedge clock) rst = 1'b1;
      // pause pair walks all four codes; i == 5 forces a failed negotiation
      {strapPins, pin, adv} = {seed[9:7], seed[4], i[1:0], (i == 5) ? 4'h0 : seed[3:0]};
      repeat (3) @(negedge clock);
      rst = 1'b0;
      repeat (5) @(negedge clock);
      host.access(1'b0, 1'b0, ELPA_ABILITY_OFS, d);
      chk("idle word", d, 32'h4001);
      negotiate();
      w = expWord(strapPins, pin, adv);
      host.access(1'b0, 1'b0, ELPA_ABILITY_OFS, d);
      chk("map word", d, {16'h0, w});
      host.access(1'b1, 1'b0, 12'h005, d);
      chk("mii word", d, {16'h0, w});
      chk("failed", anFailed, w[8:5] == 4'h0);
      chk("copy", abilityWord, w);
      strapPins = ~strapPins;
      adv = ~adv;
      host.access(1'b0, 1'b1, ELPA_ABILITY_OFS, d);
      host.access(1'b0, 1'b0, ELPA_ABILITY_OFS, d);
      chk("held word", d, {16'h0, w});
      host.access(1'b0, 1'b0, ELPA_ABILITY_OFS + 12'h4, d);
      chk("miss", d, 32'h0);
      negotiate();
      chk("rerun", abilityWord, expWord(~strapPins, pin, adv));
    end
    end_sim();
  end
endmodule
